// ==== include/iop_pkg.sv ====
// Constants and types for the general-purpose I/O port register block.
// Assumes a single system clock and a synchronous active-high reset.
//
// Summary of operation
// - Each register also answers at +0x4 clear, +0x8 set, +0xc invert.
// - Bits 31:16 of every port register read zero and ignore writes.
// - Sixteen-pin port: direction register resets to all ones, pins are inputs.
// - Twelve-pin port: only bits 11:0 exist; direction resets to ones there.
// - Pin value and output latch reset to zero (IOP_RST_UNDEFINED is 16'h0000).
// - Open-drain control resets to zero, push-pull drivers selected.
package iop_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [15:0] IOP_ADDR_DIRECTION = 16'h60c0;
	localparam logic [15:0] IOP_ADDR_VALUE = 16'h60d0;
	localparam logic [15:0] IOP_ADDR_LATCH = 16'h60e0;
	localparam logic [15:0] IOP_ADDR_OPEN_DRAIN = 16'h60f0;
	localparam int IOP_ADDR_W = 16;
	localparam int IOP_DATA_W = 32;
	localparam int IOP_PORT_W = 16;
	localparam int IOP_NUM_REGS = 4;
	// ----------------------------------------------------------------
	// Companion offsets in address bits 3:2
	// ----------------------------------------------------------------
	localparam logic [1:0] IOP_OP_PLAIN = 2'h0;
	localparam logic [1:0] IOP_OP_CLEAR = 2'h1;
	localparam logic [1:0] IOP_OP_SET = 2'h2;
	localparam logic [1:0] IOP_OP_INVERT = 2'h3;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [IOP_PORT_W-1:0] IOP_RST_DIRECTION = 16'hffff;
	localparam logic [IOP_PORT_W-1:0] IOP_RST_OPEN_DRAIN = 16'h0000;
	localparam logic [IOP_PORT_W-1:0] IOP_RST_UNDEFINED = 16'h0000;
	localparam int IOP_SYNC_STAGES = 3;
endpackage : iop_pkg

// ==== include/iop_wr_if.sv ====
// Interface carrying one decoded register update to the bit-update unit.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface iop_wr_if #(parameter int WIDTH = 16);
	logic [1:0] op;
	logic [WIDTH-1:0] old_value;
	logic [WIDTH-1:0] wdata;
	logic [WIDTH-1:0] new_value;
	modport ctrl (output op, output old_value, output wdata, input new_value);
	modport unit (input op, input old_value, input wdata, output new_value);
endinterface : iop_wr_if

// ==== logic/iop_bit_update.sv ====
// Combinational plain, clear, set and invert update of one register.
// Assumes the caller masks the result to the implemented pins.
`timescale 1ns/1ps
module iop_bit_update
	import iop_pkg::*;
(
	// Update request and result
	iop_wr_if.unit wr
);
	// ----------------------------------------------------------------
	// Atomic update
	// ----------------------------------------------------------------
	// atomic bit update
	always_comb begin
		case (wr.op)
			IOP_OP_PLAIN: wr.new_value = wr.wdata;
			IOP_OP_CLEAR: wr.new_value = wr.old_value & ~wr.wdata;
			IOP_OP_SET: wr.new_value = wr.old_value | wr.wdata;
			IOP_OP_INVERT: wr.new_value = wr.old_value ^ wr.wdata;
			default: wr.new_value = wr.old_value;
		endcase
	end
endmodule : iop_bit_update

// ==== logic/iop_port.sv ====
// Register block and pin drivers of one general-purpose I/O port.
// Assumes pins are outside the clock domain; a testbench resolves the pads.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module iop_port
	import iop_pkg::*;
#(
	parameter int PINS = 16
) (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_srst,
	// Register port
	input wire logic [iop_pkg::IOP_ADDR_W-1:0] i_addr,
	input wire logic [iop_pkg::IOP_DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [iop_pkg::IOP_DATA_W-1:0] o_rdata,
	// Pins
	input wire logic [iop_pkg::IOP_PORT_W-1:0] i_pin,
	output logic [iop_pkg::IOP_PORT_W-1:0] o_pin,
	output logic [iop_pkg::IOP_PORT_W-1:0] o_pin_oe
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [IOP_PORT_W-1:0] dir;
		logic [IOP_PORT_W-1:0] lat;
		logic [IOP_PORT_W-1:0] odc;
		logic [IOP_PORT_W-1:0] val;
		logic [IOP_SYNC_STAGES-1:0][IOP_PORT_W-1:0] sync;
		logic [IOP_DATA_W-1:0] rdata;
	} iop_state_t;

	localparam logic [IOP_PORT_W-1:0] PIN_MASK = IOP_PORT_W'((32'h1 << PINS) - 32'h1);

	iop_state_t st_q;
	iop_state_t st_d;
	logic sel_dir;
	logic sel_lat;
	logic sel_odc;
	logic sel_val;
	logic [IOP_PORT_W-1:0] old_sel;
	logic [IOP_PORT_W-1:0] upd;
	logic [IOP_PORT_W-1:0] rd_word;
	iop_wr_if #(.WIDTH(IOP_PORT_W)) wr_bus ();

	// ----------------------------------------------------------------
	// Decode: base address with bits 3:2 as the companion operation
	// ----------------------------------------------------------------
	assign sel_dir = {i_addr[IOP_ADDR_W-1:4], 4'h0} == IOP_ADDR_DIRECTION;
	assign sel_val = {i_addr[IOP_ADDR_W-1:4], 4'h0} == IOP_ADDR_VALUE;
	assign sel_lat = {i_addr[IOP_ADDR_W-1:4], 4'h0} == IOP_ADDR_LATCH;
	assign sel_odc = {i_addr[IOP_ADDR_W-1:4], 4'h0} == IOP_ADDR_OPEN_DRAIN;

	// Current value of the addressed register; value writes act on the latch
	always_comb begin
		old_sel = '0;
		if (sel_dir) begin
			old_sel = st_q.dir;
		end else if (sel_odc) begin
			old_sel = st_q.odc;
		end else if (sel_lat || sel_val) begin
			old_sel = st_q.lat;
		end
	end

	assign wr_bus.op = i_addr[3:2];
	assign wr_bus.old_value = old_sel;
	assign wr_bus.wdata = i_wdata[IOP_PORT_W-1:0];
	assign upd = wr_bus.new_value & PIN_MASK;

	iop_bit_update u_update (
		.wr(wr_bus)
	);

	// Read mux
	always_comb begin
		rd_word = '0;
		if (sel_dir) begin
			rd_word = st_q.dir;
		end else if (sel_val) begin
			rd_word = st_q.val;
		end else if (sel_lat) begin
			rd_word = st_q.lat;
		end else if (sel_odc) begin
			rd_word = st_q.odc;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		// Three-stage pin synchroniser; only stages two and three are read later
		st_d.sync[0] = i_pin;
		st_d.sync[1] = st_q.sync[0];
		st_d.sync[2] = st_q.sync[1];
		// Change accepted once stages two and three agree
		for (int b = 0; b < IOP_PORT_W; b++) begin
			if (st_q.sync[1][b] == st_q.sync[2][b]) begin
				st_d.val[b] = st_q.sync[2][b] & PIN_MASK[b];
			end
		end
		if (i_wr) begin
			if (sel_dir) begin
				st_d.dir = upd;
			end
			if (sel_odc) begin
				st_d.odc = upd;
			end
			if (sel_lat || sel_val) begin
				st_d.lat = upd;
			end
		end
		st_d.rdata = i_rd ? {{(IOP_DATA_W-IOP_PORT_W){1'b0}}, rd_word} : '0;
		if (i_srst) begin
			st_d.dir = IOP_RST_DIRECTION & PIN_MASK;
			st_d.odc = IOP_RST_OPEN_DRAIN;
			st_d.lat = IOP_RST_UNDEFINED;
			st_d.val = IOP_RST_UNDEFINED;
			st_d.sync = '0;
			st_d.rdata = '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_rdata = st_q.rdata;
	always_comb begin
		for (int b = 0; b < IOP_PORT_W; b++) begin
			o_pin[b] = st_q.odc[b] ? 1'b0 : st_q.lat[b];
			o_pin_oe[b] = PIN_MASK[b] & ~st_q.dir[b] & (~st_q.odc[b] | ~st_q.lat[b]);
		end
	end
endmodule : iop_port

// ==== verification/iop_port_chk.sv ====
// Checker bound to every port register block instance.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module iop_port_chk #(parameter int PINS = 16) (
	// Ports watched
	input wire logic i_sys_clk,
	input wire logic i_srst,
	input wire logic [15:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	input wire logic [15:0] i_pin,
	input wire logic [15:0] o_pin,
	input wire logic [15:0] o_pin_oe
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	// One write strobe at a given address
	sequence s_wr(a);
		i_wr && i_addr == a;
	endsequence
	a_upper_zero: assert property (o_rdata[31:16] == 16'h0)
		else $error("upper half not zero");
	a_rd_idle: assert property (!i_rd |=> o_rdata == 32'h0)
		else $error("read data not idle");
	a_rst_input: assert property ($fell(i_srst) |-> o_pin_oe == 16'h0)
		else $error("pin driven after reset");
	a_hi_undriven: assert property ((o_pin_oe >> PINS) == 16'h0)
		else $error("missing pin driven");
	a_dir_set_in: assert property (s_wr(16'h60c8) |=> (o_pin_oe & $past(i_wdata[15:0])) == 16'h0)
		else $error("set input still driven");
	a_clr_low: assert property (s_wr(16'h60e4) |=> (o_pin & $past(i_wdata[15:0])) == 16'h0)
		else $error("cleared latch drives high");
	a_set_nolow: assert property (s_wr(16'h60e8) |=> (o_pin_oe & ~o_pin & $past(i_wdata[15:0])) == 16'h0)
		else $error("set latch drives low");
endmodule : iop_port_chk
bind iop_port iop_port_chk #(.PINS(PINS)) u_chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe));

// ==== verification/iop_pad_model.sv ====
// Pads of the port: block drive, far device drive, else pull-up.
// Assumes the far device never fights a driven pin.
`timescale 1ns/1ps
module iop_pad_model (
	// Drives
	input wire logic [15:0] i_drv,
	input wire logic [15:0] i_drv_oe,
	input wire logic [15:0] i_ext,
	input wire logic [15:0] i_ext_en,
	// Resolved pad levels
	output logic [15:0] o_pad
);
	always_comb begin
		for (int b = 0; b < 16; b++) begin
			o_pad[b] = i_drv_oe[b] ? i_drv[b] : (i_ext_en[b] ? i_ext[b] : 1'b1);
		end
	end
endmodule : iop_pad_model

// ==== verification/tb.sv ====
// Testbench for the port register block, both pin counts.
// Assumes read data stands one cycle after the read strobe.
`timescale 1ns/1ps
module tb;
	import iop_pkg::*;
	logic clk, srst, wr, rd;
	logic [15:0] addr, pad, pin, oe, ext, ext_en;
	logic [31:0] wdata, rdata, rdata12, got12;
	int err_count, checks_done;
	logic [31:0] wd[4] = '{32'hffff1234, 32'hf0, 32'h3, 32'hffff};
	logic [31:0] ex[4] = '{32'h1234, 32'h1204, 32'h1207, 32'hedf8};
	iop_port dut (.i_sys_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_pin(pad), .o_pin(pin), .o_pin_oe(oe));
	iop_port #(.PINS(12)) dut12 (.i_sys_clk(clk), .i_srst(srst), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata12), .i_pin(pad), .o_pin(),
		.o_pin_oe());
	iop_pad_model pads (.i_drv(pin), .i_drv_oe(oe), .i_ext(ext), .i_ext_en(ext_en), .o_pad(pad));
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
	endtask : wr_reg
	task rd_chk(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1;
		got12 = rdata12;
		chk(rdata, e);
	endtask : rd_chk
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	// Watchdog
	initial begin
		#5000;
		err_count++;
		test_done;
	end
	// Main sequence
	initial begin
		{srst, wr, rd, addr, wdata, ext, ext_en} = 0;
		srst = 1;
		repeat (2) @(posedge clk);
		srst <= 0;
		rd_chk(16'h60c0, 32'hffff);
		chk(got12, 32'hfff);
		rd_chk(16'h60f0, 32'h0);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			wr_reg(16'h60c0 + 16'(4 * i), wd[i]);
			rd_chk(16'h60c0, ex[i]);
			chk(got12, ex[i] & 32'hfff);
		end
		$display("companion test done");
		wr_reg(16'h60e0, 32'ha5a5);
		wr_reg(16'h60c0, 32'h0);
		repeat (5) @(posedge clk);
		#1;
		chk({pin, oe}, 32'ha5a5ffff);
		rd_chk(16'h60d0, 32'ha5a5);
		wr_reg(16'h60f0, 32'hffff);
		repeat (2) @(posedge clk);
		#1;
		chk({16'h0, oe}, 32'h5a5a);
		wr_reg(16'h60e8, 32'h00ff);
		repeat (2) @(posedge clk);
		#1;
		chk({pin, oe}, 32'h00005a00);
		wr_reg(16'h60e4, 32'hff00);
		repeat (2) @(posedge clk);
		#1;
		chk({pin, oe}, 32'h0000ff00);
		wr_reg(16'h60c0, 32'hffff);
		ext <= 16'h3c3c;
		ext_en <= 16'hff00;
		repeat (6) @(posedge clk);
		rd_chk(16'h60d0, 32'h3cff);
		$display("pin test done");
		wr_reg(16'h6100, 32'h1);
		rd_chk(16'h6100, 32'h0);
		rd_chk(16'h60c0, 32'hffff);
		$display("unmapped test done");
		test_done;
	end
endmodule : tb
